// File: inc/blr_pkg.sv
// Package of constants and types for the link-loss reaction and fault code block.
package blr_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned IDX_W        = 16;
  localparam logic [15:0] IDX_REACT    = 16'h6007;
  localparam logic [15:0] IDX_PROFILE  = 16'h603f;
  localparam logic [15:0] IDX_CTRL     = 16'h0000;
  localparam logic [15:0] IDX_INTERNAL = 16'h0001;
  localparam logic [15:0] IDX_NATIVE   = 16'h0002;
  localparam logic [15:0] IDX_IRQ_STS  = 16'h0003;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0004;
  localparam logic [15:0] IDX_LINK     = 16'h0005;

  // Internal reaction setting, stored form of the bus-visible code.
  localparam logic [2:0] R_NONE   = 3'h0;
  localparam logic [2:0] R_FAULT  = 3'h1;
  localparam logic [2:0] R_SWOFF  = 3'h2;
  localparam logic [2:0] R_QSTOP  = 3'h3;
  localparam logic [2:0] R_RAMP   = 3'h4;
  localparam logic [2:0] R_NONE2  = 3'h5;
  localparam logic [2:0] R_RESET  = R_FAULT;
  localparam logic [15:0] CODE_RAMP  = 16'hffff;
  localparam logic [15:0] CODE_NONE2 = 16'hfffe;
  localparam logic signed [15:0] CODE_MIN = 16'shfffe;
  localparam logic signed [15:0] CODE_MAX = 16'sh0003;

  // Native fault numbers in the upper byte of the native code, and profile codes.
  localparam logic [7:0]  FN_NONE     = 8'h00;
  localparam logic [7:0]  FN_OVERLOAD = 8'h01;
  localparam logic [7:0]  FN_CASE     = 8'h02;
  localparam logic [7:0]  FN_INSIDE   = 8'h03;
  localparam logic [7:0]  FN_MOTOR    = 8'h04;
  localparam logic [7:0]  FN_CURRENT  = 8'h05;
  localparam logic [7:0]  FN_DCLINK   = 8'h07;
  localparam logic [7:0]  FN_SUPPLY   = 8'h08;
  localparam logic [7:0]  FN_EARTH    = 8'h0d;
  localparam logic [15:0] PC_NONE     = 16'h0000;
  localparam logic [15:0] PC_OVERLOAD = 16'h2310;
  localparam logic [15:0] PC_CASE     = 16'h4210;
  localparam logic [15:0] PC_INSIDE   = 16'h4110;
  localparam logic [15:0] PC_MOTOR    = 16'h4310;
  localparam logic [15:0] PC_CURRENT  = 16'h2340;
  localparam logic [15:0] PC_DCLINK   = 16'h3210;
  localparam logic [15:0] PC_SUPPLY   = 16'h5111;
  localparam logic [15:0] PC_EARTH    = 16'h2330;
  localparam logic [15:0] PC_GENERIC  = 16'h1000;

  // Control and interrupt bit positions.
  localparam int unsigned CTRL_CONTACT = 0;
  localparam int unsigned CTRL_SAVE    = 1;
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_LINK     = 0;
  localparam int unsigned IRQ_FAULT    = 1;
  localparam int unsigned IRQ_STOPPED  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_ARMED = 2'h0,
    ST_RAMP  = 2'h1,
    ST_DOWN  = 2'h3
  } blr_fsm_t;

  typedef struct packed {
    logic bus_off;
    logic guard_timeout;
    logic heartbeat_loss;
    logic sync_error;
    logic rx_length_error;
    logic left_operational;
  } blr_cause_t;

  typedef struct packed {
    logic enter_fault;
    logic disable_voltage;
    logic quick_stop;
    logic disable_operation;
    logic to_switch_on_disabled;
  } blr_cmd_t;

  // Byte 0 is the least significant byte.
  typedef struct packed {
    logic [31:0] native;
    logic [15:0] spare;
    logic [15:0] profile;
  } blr_emcy_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              aw_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              w_got;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        react;
    logic              contact;
    logic [15:0]       profile;
    logic [15:0]       native;
    logic [IRQ_W-1:0]  sts;
    logic [IRQ_W-1:0]  mask;
    logic              irq;
    blr_fsm_t          fsm;
    logic              booted;
    blr_cmd_t          cmd;
    blr_emcy_t         emcy;
    logic              emcy_valid;
    logic              save;
    logic [15:0]       save_code;
  } blr_state_t;

  localparam blr_state_t ST_RST = '{react: R_RESET, fsm: ST_ARMED, default: '0};

endpackage

// File: tb/blr_drive_model.sv
// Model of the drive and parameter store behind the reaction outputs.
`timescale 1ns/100ps
module blr_drive_model #(
  parameter int STOP_CYC = 4
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Drive commands and standstill.
  input  wire blr_pkg::blr_cmd_t sm_cmd,
  output logic                   drive_stopped,
  // Parameter store.
  input  wire logic              nv_save,
  input  wire logic [15:0]       nv_save_code,
  output logic                   nv_restore_valid,
  output logic [15:0]            nv_restore_code
);
  int          cnt_ff;
  logic        vld_ff = 1'b0;
  logic [15:0] code_ff = 16'h0000;

  assign nv_restore_valid = vld_ff;
  assign nv_restore_code  = code_ff;

  // The store ignores reset, as non-volatile memory would.
  always @(posedge aclk) begin
    if (nv_save) begin
      vld_ff <= 1'b1;
      code_ff <= nv_save_code;
    end
    if (!aresetn || sm_cmd.enter_fault) begin
      cnt_ff <= 0;
      drive_stopped <= 1'b0;
    end else if (sm_cmd.disable_operation) begin
      cnt_ff <= STOP_CYC;
    end else if (cnt_ff == 1) begin
      cnt_ff <= 0;
      drive_stopped <= 1'b1;
    end else if (cnt_ff > 1) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule

// File: tb/blr_properties.sv
// Concurrent checks on reaction commands and emergency contents.
`timescale 1ns/100ps
module blr_properties (
  // Clock and reset.
  input wire logic                aclk,
  input wire logic                aresetn,
  // Link and drive.
  input wire blr_pkg::blr_cause_t link_cause,
  input wire logic                drive_stopped,
  input wire blr_pkg::blr_cmd_t   sm_cmd,
  // Fault reports.
  input wire logic                fault_valid,
  input wire logic [15:0]         fault_native,
  input wire blr_pkg::blr_emcy_t  emcy_data,
  input wire logic                emcy_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rep(logic [7:0] fn);
    fault_valid && fault_native[15:8] == fn;
  endsequence
  sequence s_code(logic [15:0] pc);
    emcy_valid && emcy_data.profile == pc;
  endsequence
  sequence s_other;
    fault_valid && !(fault_native[15:8] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h05, 8'h07, 8'h08, 8'h0d});
  endsequence

  property p_pulse;
    fault_valid |=> emcy_valid;
  endproperty
  property p_native;
    fault_valid |=> emcy_data.native == {16'h0, $past(fault_native)} && emcy_data.spare == 0;
  endproperty
  property p_none;
    s_rep(8'h00) |=> s_code(16'h0000);
  endproperty
  property p_earth;
    s_rep(8'h0d) |=> s_code(16'h2330);
  endproperty
  property p_overload;
    s_rep(8'h01) |=> s_code(16'h2310);
  endproperty
  property p_current;
    s_rep(8'h05) |=> s_code(16'h2340);
  endproperty
  property p_generic;
    s_other |=> s_code(16'h1000);
  endproperty
  property p_cause;
    sm_cmd != 5'h00 |-> $past(|link_cause) || $past(drive_stopped);
  endproperty
  property p_sod;
    sm_cmd.to_switch_on_disabled |-> sm_cmd.disable_voltage ^ sm_cmd.quick_stop;
  endproperty

  a_pulse: assert property (p_pulse) else $error("Emergency pulse missing.");
  a_native: assert property (p_native) else $error("Native bytes wrong.");
  a_none: assert property (p_none) else $error("No-fault code wrong.");
  a_earth: assert property (p_earth) else $error("Earth fault code wrong.");
  a_overload: assert property (p_overload) else $error("Overload code wrong.");
  a_current: assert property (p_current) else $error("Overcurrent code wrong.");
  a_generic: assert property (p_generic) else $error("Generic code wrong.");
  a_cause: assert property (p_cause) else $error("Command without cause.");
  a_sod: assert property (p_sod) else $error("Shutdown command alone.");
endmodule

bind blr_unit blr_properties u_props (
  .aclk, .aresetn, .link_cause, .drive_stopped, .sm_cmd,
  .fault_valid, .fault_native, .emcy_data, .emcy_valid
);

// File: tb/test_bus_loss_reaction_error_code.sv
// Self-checking bench for the link-loss reaction and fault code block.
`timescale 1ns/100ps
module test_bus_loss_reaction_error_code;
  logic                       aclk, aresetn, fault_valid, drive_stopped, emcy_valid;
  logic [blr_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]                s_axi_wdata, s_axi_rdata;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp, s_axi_rresp;
  logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready, nv_save, nv_restore_valid, irq;
  logic [15:0]                fault_native, nv_save_code, nv_restore_code, saved;
  blr_pkg::blr_cause_t        link_cause;
  blr_pkg::blr_cmd_t          sm_cmd;
  blr_pkg::blr_emcy_t         emcy_data;
  logic [4:0]                 seen;
  logic                       clr_seen;
  int                         n_errors, checks, nc;
  logic [15:0] code_tab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hffff, 16'hfffe};
  logic [4:0]  sm_tab [6] = '{5'h00, 5'h10, 5'h09, 5'h05, 5'h12, 5'h00};
  logic [4:0]  ct_tab [6] = '{5'h00, 5'h10, 5'h10, 5'h10, 5'h10, 5'h00};

  blr_unit uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .link_cause, .drive_stopped, .sm_cmd, .fault_valid, .fault_native,
    .emcy_data, .emcy_valid, .nv_save, .nv_save_code, .nv_restore_valid, .nv_restore_code, .irq
  );
  blr_drive_model #(.STOP_CYC(4)) u_drive (
    .aclk, .aresetn, .sm_cmd, .drive_stopped, .nv_save, .nv_save_code,
    .nv_restore_valid, .nv_restore_code
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // One-cycle command pulses are easy to miss, so they are gathered here.
  always @(posedge aclk) begin
    seen <= clr_seen ? 5'h00 : seen | sm_cmd;
    if (nv_save) saved <= nv_save_code;
  end

  task automatic finish_test();
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_chk(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic a, w, b;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic a, r;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      if (r) chk("rdata", ed, s_axi_rdata);
      if (r) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic t_link(input logic c, input logic [15:0] code, input logic [4:0] exp);
    wr_chk(blr_pkg::IDX_CTRL, {31'h0, c}, 2'h0);
    wr_chk(blr_pkg::IDX_REACT, {16'h0, code}, 2'h0);
    clr_seen <= 1'b1;
    @(posedge aclk);
    clr_seen <= 1'b0;
    link_cause <= blr_pkg::blr_cause_t'(6'h01 << (nc % 6));
    nc++;
    repeat (12) @(posedge aclk);
    link_cause <= '0;
    @(negedge aclk);
    chk("sm_cmd", {27'h0, exp}, {27'h0, seen});
    repeat (3) @(negedge aclk);
  endtask

  task automatic t_range();
    wr_chk(blr_pkg::IDX_REACT, 32'h2, 2'h0);
    wr_chk(blr_pkg::IDX_REACT, 32'h4, 2'h2);
    wr_chk(blr_pkg::IDX_REACT, 32'hfffd, 2'h2);
    rd_chk(blr_pkg::IDX_REACT, 32'h2, 2'h0);
    wr_chk(blr_pkg::IDX_INTERNAL, 32'h4, 2'h0);
    rd_chk(blr_pkg::IDX_REACT, 32'hffff, 2'h0);
    wr_chk(blr_pkg::IDX_REACT, 32'hfffe, 2'h0);
    rd_chk(blr_pkg::IDX_INTERNAL, 32'h5, 2'h0);
    wr_chk(blr_pkg::IDX_INTERNAL, 32'h6, 2'h2);
    wr_chk(blr_pkg::IDX_PROFILE, 32'h1234, 2'h2);
    rd_chk(16'h0100, 32'h0, 2'h2);
  endtask

  task automatic t_irq();
    wr_chk(blr_pkg::IDX_IRQ_MASK, 32'h0, 2'h0);
    wr_chk(blr_pkg::IDX_IRQ_STS, 32'h7, 2'h0);
    t_link(1'b0, 16'h0000, 5'h00);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd_chk(blr_pkg::IDX_IRQ_STS, 32'h1, 2'h0);
    wr_chk(blr_pkg::IDX_IRQ_MASK, 32'h1, 2'h0);
    repeat (2) @(negedge aclk);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr_chk(blr_pkg::IDX_IRQ_STS, 32'h1, 2'h0);
    repeat (2) @(negedge aclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask

  task automatic t_faults();
    logic [7:0]  fn [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0d,
      8'h06, 8'hff};
    logic [15:0] pc [11] = '{16'h0000, 16'h2310, 16'h4210, 16'h4110, 16'h4310, 16'h2340,
      16'h3210, 16'h5111, 16'h2330, 16'h1000, 16'h1000};
    for (int i = 0; i < 11; i++) begin
      @(posedge aclk);
      fault_valid <= 1'b1;
      fault_native <= {fn[i], 8'h5a};
      @(posedge aclk);
      fault_valid <= 1'b0;
      @(negedge aclk);
      chk("emcy_valid", 32'h1, {31'h0, emcy_valid});
      chk("emcy_low", {16'h0, pc[i]}, emcy_data[31:0]);
      chk("emcy_high", {16'h0, fn[i], 8'h5a}, emcy_data[63:32]);
      rd_chk(blr_pkg::IDX_PROFILE, {16'h0, pc[i]}, 2'h0);
      rd_chk(blr_pkg::IDX_NATIVE, {16'h0, fn[i], 8'h5a}, 2'h0);
    end
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h3;
    link_cause = '0;
    fault_valid = 1'b0;
    fault_native = 16'h0000;
    clr_seen = 1'b1;
    {n_errors, checks, nc} = '0;
    do_reset();
    rd_chk(blr_pkg::IDX_REACT, 32'h1, 2'h0);
    rd_chk(blr_pkg::IDX_INTERNAL, 32'h1, 2'h0);
    rd_chk(blr_pkg::IDX_CTRL, 32'h0, 2'h0);
    t_range();
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 6; i++) begin
        t_link(c[0], code_tab[i], c[0] ? ct_tab[i] : sm_tab[i]);
      end
    end
    t_irq();
    t_faults();
    rd_chk(blr_pkg::IDX_IRQ_STS, 32'h2, 2'h0);
    wr_chk(blr_pkg::IDX_REACT, 32'h3, 2'h0);
    wr_chk(blr_pkg::IDX_CTRL, 32'h2, 2'h0);
    @(negedge aclk);
    chk("nv_save_code", 32'h3, {16'h0, saved});
    do_reset();
    rd_chk(blr_pkg::IDX_REACT, 32'h3, 2'h0);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    finish_test();
  end
endmodule

// File: verilog/blr_unit.sv
// Link-loss reaction selector and last-fault code recorder with an AXI4-Lite register slave.
`timescale 1ns/100ps

// Function
// RQ1: Link failure from any cause triggers reaction.
// RQ2: Codes 0 and -2 keep operating point.
// RQ3: Code 1 enters fault immediately.
// RQ4: Codes 2/3 command, then switch-on-disabled.
// RQ5: Code -1 ramps down, fault once stopped.
// RQ6: Contact control: codes 1-3 force fault; the logic also forces fault for code -1 instead of ramping.
// RQ7: Reaction code signed, limited -2 to 3.
// RQ8: Internal setting and code are one value.
// RQ9: Save stores code; power-on restore overrides.
// RQ10: Last fault profile code, read only.
// RQ11: Thermal faults map to their profile codes.
// RQ12: Electrical faults map to their profile codes.
// RQ13: Earth fault 0x2330, no fault 0x0000.
// RQ14: Other faults generic; native code readable.
// RQ15: Emergency: profile bytes 0-1, native 4-7.
module blr_unit (
  // Clock and reset.
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [blr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [blr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Link supervision and drive state.
  input  wire blr_pkg::blr_cause_t        link_cause,
  input  wire logic                       drive_stopped,
  output blr_pkg::blr_cmd_t               sm_cmd,
  // Fault reports and emergency message contents.
  input  wire logic                       fault_valid,
  input  wire logic [15:0]                fault_native,
  output blr_pkg::blr_emcy_t              emcy_data,
  output logic                            emcy_valid,
  // Non-volatile parameter store.
  output logic                            nv_save,
  output logic [15:0]                     nv_save_code,
  input  wire logic                       nv_restore_valid,
  input  wire logic [15:0]                nv_restore_code,
  // Interrupt.
  output logic                            irq
);

  blr_pkg::blr_state_t st_ff;
  blr_pkg::blr_state_t nxt_st;

  // Negative codes read back as their 16-bit pattern, zero-extended in the word.
  function automatic logic [15:0] code_of(
    input logic [2:0] r
  );
    logic [15:0] c;
    c = {13'h0000, r};
    if (r == blr_pkg::R_RAMP) begin
      c = blr_pkg::CODE_RAMP;
    end else if (r == blr_pkg::R_NONE2) begin
      c = blr_pkg::CODE_NONE2;
    end
    return c;
  endfunction

  function automatic logic in_range(
    input logic [15:0] c
  );
    return ($signed(c) >= blr_pkg::CODE_MIN) &&
           ($signed(c) <= blr_pkg::CODE_MAX);
  endfunction

  // Only codes that passed the range check reach this, so the low bits suffice.
  function automatic logic [2:0] internal_of(
    input logic [15:0] c
  );
    logic [2:0] r;
    r = c[2:0];
    if (c == blr_pkg::CODE_RAMP) begin
      r = blr_pkg::R_RAMP;
    end else if (c == blr_pkg::CODE_NONE2) begin
      r = blr_pkg::R_NONE2;
    end
    return r;
  endfunction

  // The sub code in the low byte only survives in the native item.
  function automatic logic [15:0] profile_of(
    input logic [15:0] n
  );
    logic [15:0] p;
    unique case (n[15:8])
      blr_pkg::FN_NONE: begin
        p = blr_pkg::PC_NONE;
      end
      blr_pkg::FN_OVERLOAD: begin
        p = blr_pkg::PC_OVERLOAD;
      end
      blr_pkg::FN_CASE: begin
        p = blr_pkg::PC_CASE;
      end
      blr_pkg::FN_INSIDE: begin
        p = blr_pkg::PC_INSIDE;
      end
      blr_pkg::FN_MOTOR: begin
        p = blr_pkg::PC_MOTOR;
      end
      blr_pkg::FN_CURRENT: begin
        p = blr_pkg::PC_CURRENT;
      end
      blr_pkg::FN_DCLINK: begin
        p = blr_pkg::PC_DCLINK;
      end
      blr_pkg::FN_SUPPLY: begin
        p = blr_pkg::PC_SUPPLY;
      end
      blr_pkg::FN_EARTH: begin
        p = blr_pkg::PC_EARTH;
      end
      default: begin
        p = blr_pkg::PC_GENERIC;
      end
    endcase
    return p;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  strb
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  always_comb begin
    logic [15:0]              widx;
    logic [15:0]              ridx;
    logic [31:0]              m;
    logic [blr_pkg::IRQ_W-1:0] set;
    logic [blr_pkg::IRQ_W-1:0] clr;
    logic                     any_cause;
    widx      = st_ff.awaddr[blr_pkg::ADDR_W-1:2];
    ridx      = s_axi_araddr[blr_pkg::ADDR_W-1:2];
    m         = 32'h0000_0000;
    set       = '0;
    clr       = '0;
    any_cause = |link_cause;
    nxt_st            = st_ff;
    nxt_st.cmd        = '0;
    nxt_st.emcy_valid = 1'b0;
    nxt_st.save       = 1'b0;

    // Address and data are taken in either order and held until both are in.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.awaddr = s_axi_awaddr;
      nxt_st.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
      nxt_st.w_got = 1'b1;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // The merged word is range checked, the reaction code in its low half only, so partial strobes cannot store a bad code.
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = blr_pkg::RESP_OKAY;
      unique case (widx)
        blr_pkg::IDX_REACT: begin
          m = merge({16'h0000, code_of(st_ff.react)}, st_ff.wdata, st_ff.wstrb);
          if (in_range(m[15:0])) begin // RQ7
            nxt_st.react = internal_of(m[15:0]); // RQ8
          end else begin
            nxt_st.bresp = blr_pkg::RESP_SLVERR;
          end
        end
        blr_pkg::IDX_INTERNAL: begin
          m = merge({29'h0000_0000, st_ff.react}, st_ff.wdata, st_ff.wstrb);
          if (m[31:3] == 29'h0000_0000 && m[2:0] <= blr_pkg::R_NONE2) begin
            nxt_st.react = m[2:0]; // RQ8
          end else begin
            nxt_st.bresp = blr_pkg::RESP_SLVERR;
          end
        end
        blr_pkg::IDX_CTRL: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.contact = st_ff.wdata[blr_pkg::CTRL_CONTACT];
            if (st_ff.wdata[blr_pkg::CTRL_SAVE]) begin
              nxt_st.save      = 1'b1; // RQ9
              nxt_st.save_code = code_of(st_ff.react); // RQ9
            end
          end
        end
        blr_pkg::IDX_IRQ_STS: begin
          if (st_ff.wstrb[0]) begin
            clr = st_ff.wdata[blr_pkg::IRQ_W-1:0];
          end
        end
        blr_pkg::IDX_IRQ_MASK: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.mask = st_ff.wdata[blr_pkg::IRQ_W-1:0];
          end
        end
        // Read-only items and unmapped addresses refuse the write.
        default: begin
          nxt_st.bresp = blr_pkg::RESP_SLVERR; // RQ10
        end
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = blr_pkg::RESP_OKAY;
      unique case (ridx)
        blr_pkg::IDX_REACT: begin
          nxt_st.rdata = {16'h0000, code_of(st_ff.react)}; // RQ8
        end

        blr_pkg::IDX_PROFILE: begin
          nxt_st.rdata = {16'h0000, st_ff.profile}; // RQ10
        end

        blr_pkg::IDX_CTRL: begin
          nxt_st.rdata = {31'h0000_0000, st_ff.contact};
        end

        blr_pkg::IDX_INTERNAL: begin
          nxt_st.rdata = {29'h0000_0000, st_ff.react};
        end

        blr_pkg::IDX_NATIVE: begin
          nxt_st.rdata = {16'h0000, st_ff.native}; // RQ14
        end

        blr_pkg::IDX_IRQ_STS: begin
          nxt_st.rdata = {29'h0000_0000, st_ff.sts};
        end

        blr_pkg::IDX_IRQ_MASK: begin
          nxt_st.rdata = {29'h0000_0000, st_ff.mask};
        end

        blr_pkg::IDX_LINK: begin
          nxt_st.rdata = {24'h00_0000, link_cause, st_ff.fsm};
        end

        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = blr_pkg::RESP_SLVERR;
        end
      endcase
    end

    // The stored code wins over the reset value on the first cycle after reset.
    if (!st_ff.booted) begin
      nxt_st.booted = 1'b1;
      if (nv_restore_valid && in_range(nv_restore_code)) begin
        nxt_st.react = internal_of(nv_restore_code); // RQ9
      end
    end

    // Reaction to a failed link is taken once per failure, then rearmed on recovery.
    unique case (st_ff.fsm)
      blr_pkg::ST_ARMED: begin
        if (any_cause) begin // RQ1
          set[blr_pkg::IRQ_LINK] = 1'b1;
          nxt_st.fsm = blr_pkg::ST_DOWN;
          if (st_ff.react == blr_pkg::R_NONE || st_ff.react == blr_pkg::R_NONE2) begin
            nxt_st.cmd = '0; // RQ2
          end else if (st_ff.contact || st_ff.react == blr_pkg::R_FAULT) begin
            nxt_st.cmd.enter_fault = 1'b1; // RQ3 RQ6
          end else if (st_ff.react == blr_pkg::R_SWOFF) begin
            nxt_st.cmd.disable_voltage       = 1'b1; // RQ4
            nxt_st.cmd.to_switch_on_disabled = 1'b1; // RQ4
          end else if (st_ff.react == blr_pkg::R_QSTOP) begin
            nxt_st.cmd.quick_stop            = 1'b1; // RQ4
            nxt_st.cmd.to_switch_on_disabled = 1'b1; // RQ4
          end else begin
            nxt_st.cmd.disable_operation = 1'b1; // RQ5
            nxt_st.fsm                   = blr_pkg::ST_RAMP;
          end
        end
      end

      blr_pkg::ST_RAMP: begin
        if (drive_stopped) begin
          nxt_st.cmd.enter_fault    = 1'b1; // RQ5
          set[blr_pkg::IRQ_STOPPED] = 1'b1;
          nxt_st.fsm                = blr_pkg::ST_DOWN;
        end
      end

      blr_pkg::ST_DOWN: begin
        if (!any_cause) begin
          nxt_st.fsm = blr_pkg::ST_ARMED;
        end
      end

      default: begin
        nxt_st.fsm = blr_pkg::ST_ARMED;
      end
    endcase

    // Every report, the no-fault one included, refreshes the codes and the message.
    if (fault_valid) begin
      nxt_st.native          = fault_native; // RQ14
      nxt_st.profile         = profile_of(fault_native); // RQ11 RQ12 RQ13 RQ14
      nxt_st.emcy.profile    = profile_of(fault_native); // RQ15
      nxt_st.emcy.spare      = 16'h0000;
      nxt_st.emcy.native     = {16'h0000, fault_native}; // RQ15
      nxt_st.emcy_valid      = 1'b1;
      set[blr_pkg::IRQ_FAULT] = (fault_native != 16'h0000);
    end

    // A new event in the clearing cycle stays set.
    nxt_st.sts = (st_ff.sts & ~clr) | set;
    nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
  end

  // Reset reloads the whole state, so the reaction setting restarts at code 1.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= blr_pkg::ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A single outstanding write and read keep the slave free of queues.
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign sm_cmd        = st_ff.cmd;
  assign emcy_data     = st_ff.emcy;
  assign emcy_valid    = st_ff.emcy_valid;
  assign nv_save       = st_ff.save;
  assign nv_save_code  = st_ff.save_code;
  assign irq           = st_ff.irq;

endmodule
